/* hdl/output_relay_logic.sv */
// Operation
// - A relay turns active when any condition mapped to it is present.
// - A relay stays inactive while none of its mapped conditions is present.
// - A latching relay stays active until reset key or external reset.
// - Trip and second auxiliary relays always latch.
// - A non-latching relay drops out by itself once its conditions clear.
// - Fail-safe relay: coil energized when inactive, released when active.
// - Second auxiliary relay always uses fail-safe coil polarity.
// - Non-fail-safe relay: coil released when inactive, energized when active.
// - A flash message shows for two seconds, then the prior line returns.
// - A line is two rows of 24 characters; exactly one line shows.
// - Thermal accumulator reaching full scale raises an overload trip.
// - Four display modes; actual values and setpoints have pages.
`timescale 1ns/1ps
`default_nettype none
module output_relay_logic
   import relay_pkg::*;
#(
   parameter int FLASH_CNT = FLASH_CYCLES
) (
   // Clock and reset
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_n_in,
   // Register port
   input  wire logic [ADDR_W-1:0]     reg_addr_in,
   input  wire logic [31:0]           reg_wdata_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   output logic      [31:0]           reg_rdata_out,
   // Protection conditions and thermal model steps
   input  wire logic [EXT_COND_W-1:0] cond_in,
   input  wire logic                  heat_valid_in,
   input  wire logic [THERM_W-1:0]    heat_amt_in,
   input  wire logic                  cool_valid_in,
   input  wire logic [THERM_W-1:0]    cool_amt_in,
   // Operator reset
   input  wire logic                  reset_key_in,
   input  wire logic                  ext_reset_in,
   // Flash request from keys or timers
   input  wire logic                  flash_req_in,
   input  wire logic [LINE_W-1:0]     flash_line_in,
   // Relay outputs
   output logic      [NUM_RELAYS-1:0] relay_active_out,
   output logic      [NUM_RELAYS-1:0] coil_out,
   output logic                       overload_trip_out,
   // Display view
   output disp_view_type              disp_view_out,
   output logic                       flash_active_out
);

   logic [COND_W-1:0]     map_r [NUM_RELAYS];
   logic [NUM_RELAYS-1:0] latch_r;
   logic [NUM_RELAYS-1:0] fs_r;
   logic [NUM_RELAYS-1:0] active_r;
   logic [NUM_RELAYS-1:0] hit;
   logic [NUM_RELAYS-1:0] eff_latch;
   logic [NUM_RELAYS-1:0] eff_fs;
   logic [THERM_W-1:0]    therm_r;
   logic [THERM_W:0]      therm_sum;
   logic                  overload;
   logic [COND_W-1:0]     all_cond;
   logic                  rst_req;
   disp_view_type         sel_r;
   disp_view_type         view_r;
   logic                  flash_r;
   logic [31:0]           flash_cnt_r;
   logic [LINE_W-1:0]     flash_line_r;
   logic                  flash_go;
   logic [LINE_W-1:0]     flash_go_line;
   logic [31:0]           rdata_r;

   function automatic disp_mode_type sel_to_mode(input logic [1:0] sel);
      case (sel)
         2'h0:    sel_to_mode = MODE_ACTUAL;
         2'h1:    sel_to_mode = MODE_SETPOINT;
         2'h2:    sel_to_mode = MODE_HELP;
         default: sel_to_mode = MODE_TRIPALARM;
      endcase
   endfunction

   function automatic logic [1:0] mode_to_sel(input disp_mode_type m);
      case (m)
         MODE_ACTUAL:   mode_to_sel = 2'h0;
         MODE_SETPOINT: mode_to_sel = 2'h1;
         MODE_HELP:     mode_to_sel = 2'h2;
         default:       mode_to_sel = 2'h3;
      endcase
   endfunction

   function automatic logic wr_at(input logic [ADDR_W-1:0] a);
      wr_at = reg_wr_in && (reg_addr_in == a);
   endfunction

   assign overload  = (therm_r >= THERM_FULL);
   assign all_cond  = {overload, cond_in};
   assign rst_req   = reset_key_in | ext_reset_in;
   assign eff_latch = latch_r | FORCED_LATCH;
   assign eff_fs    = fs_r | FORCED_FS;

   // Per-relay activation and coil drive
   genvar gi;
   generate
      for (gi = 0; gi < NUM_RELAYS; gi++) begin : g_relay
         assign hit[gi] = |(all_cond & map_r[gi]);

         always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               map_r[gi] <= RST_MAP;
            end else if (wr_at(ADDR_MAP0 + 8'(4 * gi))) begin
               map_r[gi] <= reg_wdata_in[COND_W-1:0];
            end
         end

         // Present condition wins over a reset request
         always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               active_r[gi] <= 1'b0;
            end else if (hit[gi]) begin
               active_r[gi] <= 1'b1;
            end else if (eff_latch[gi] && !rst_req) begin
               active_r[gi] <= active_r[gi];
            end else begin
               active_r[gi] <= 1'b0;
            end
         end

         // Fail-safe coils drop when power fails, so trip shows then
         assign coil_out[gi] = eff_fs[gi] ? ~active_r[gi]
                                          : active_r[gi];
      end
   endgenerate

   assign relay_active_out  = active_r;
   assign overload_trip_out = overload;

   // Configuration registers
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         latch_r <= RST_LATCH;
         fs_r    <= RST_FAILSAFE;
      end else begin
         if (wr_at(ADDR_LATCH)) begin
            latch_r <= reg_wdata_in[NUM_RELAYS-1:0];
         end
         if (wr_at(ADDR_FAILSAFE)) begin
            fs_r <= reg_wdata_in[NUM_RELAYS-1:0];
         end
      end
   end

   // Thermal memory, saturating; a software write overrides steps
   always_comb begin
      therm_sum = {1'b0, therm_r};
      if (heat_valid_in) begin
         therm_sum = therm_sum + {1'b0, heat_amt_in};
      end
      if (cool_valid_in) begin
         if (therm_sum > {1'b0, cool_amt_in}) begin
            therm_sum = therm_sum - {1'b0, cool_amt_in};
         end else begin
            therm_sum = '0;
         end
      end
      if (therm_sum > {1'b0, THERM_FULL}) begin
         therm_sum = {1'b0, THERM_FULL};
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         therm_r <= RST_THERMAL;
      end else if (wr_at(ADDR_THERMAL)) begin
         therm_r <= reg_wdata_in[THERM_W-1:0];
      end else begin
         therm_r <= therm_sum[THERM_W-1:0];
      end
   end

   // Display selection; pages exist only in two modes
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sel_r <= '{mode: MODE_ACTUAL, page: '0, line: '0};
      end else if (wr_at(ADDR_DISPLAY)) begin
         sel_r.mode <= sel_to_mode(reg_wdata_in[DSP_MODE_LSB +: 2]);
         sel_r.line <= reg_wdata_in[DSP_LINE_LSB +: LINE_W];
         if (reg_wdata_in[DSP_MODE_LSB+1]) begin
            sel_r.page <= '0;
         end else begin
            sel_r.page <= reg_wdata_in[DSP_PAGE_LSB +: PAGE_W];
         end
      end
   end

   // Flash timer; a new request restarts the two seconds
   assign flash_go      = flash_req_in | wr_at(ADDR_FLASH);
   assign flash_go_line = flash_req_in ? flash_line_in
                                       : reg_wdata_in[LINE_W-1:0];

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flash_r      <= 1'b0;
         flash_cnt_r  <= '0;
         flash_line_r <= '0;
      end else if (flash_go) begin
         flash_r      <= 1'b1;
         flash_cnt_r  <= 32'(FLASH_CNT - 1);
         flash_line_r <= flash_go_line;
      end else if (flash_r) begin
         if (flash_cnt_r == '0) begin
            flash_r <= 1'b0;
         end else begin
            flash_cnt_r <= flash_cnt_r - 32'h1;
         end
      end
   end

   // Exactly one line shown: the flash line overlays the selection
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         view_r <= '{mode: MODE_ACTUAL, page: '0, line: '0};
      end else begin
         view_r.mode <= sel_r.mode;
         view_r.page <= sel_r.page;
         view_r.line <= flash_r ? flash_line_r : sel_r.line;
      end
   end

   assign disp_view_out    = view_r;
   assign flash_active_out = flash_r;

   // Read port; unmapped offsets read zero
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_r <= '0;
      end else if (reg_rd_in) begin
         rdata_r <= '0;
         case (reg_addr_in)
            ADDR_MAP0:     rdata_r[COND_W-1:0] <= map_r[REL_TRIP];
            ADDR_MAP1:     rdata_r[COND_W-1:0] <= map_r[REL_ALARM];
            ADDR_MAP2:     rdata_r[COND_W-1:0] <= map_r[REL_AUX1];
            ADDR_MAP3:     rdata_r[COND_W-1:0] <= map_r[REL_AUX2];
            ADDR_LATCH:    rdata_r[NUM_RELAYS-1:0] <= latch_r;
            ADDR_FAILSAFE: rdata_r[NUM_RELAYS-1:0] <= fs_r;
            ADDR_STATUS: begin
               rdata_r[ST_ACTIVE_LSB +: NUM_RELAYS] <= active_r;
               rdata_r[ST_COIL_LSB +: NUM_RELAYS]   <= coil_out;
               rdata_r[ST_OVL_BIT]                  <= overload;
               rdata_r[ST_FLASH_BIT]                <= flash_r;
            end
            ADDR_DISPLAY: begin
               rdata_r[DSP_LINE_LSB +: LINE_W] <= sel_r.line;
               rdata_r[DSP_PAGE_LSB +: PAGE_W] <= sel_r.page;
               rdata_r[DSP_MODE_LSB +: 2]      <= mode_to_sel(sel_r.mode);
            end
            ADDR_FLASH:    rdata_r[LINE_W-1:0] <= flash_line_r;
            ADDR_THERMAL:  rdata_r[THERM_W-1:0] <= therm_r;
            default:       rdata_r <= '0;
         endcase
      end
   end

   assign reg_rdata_out = rdata_r;

   // Checks
   AST_ACT_ON_COND: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) (hit != '0) |=> ((active_r & $past(hit)) ==
      $past(hit))) else $error("mapped condition did not activate relay");
   AST_IDLE_NO_COND: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) $rose(active_r[REL_ALARM]) |->
      $past(hit[REL_ALARM])) else $error("relay activated without cause");
   AST_LATCH_HOLD: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) (active_r[REL_ALARM] && latch_r[REL_ALARM]
      && !rst_req) |=> active_r[REL_ALARM])
      else $error("latched relay dropped without reset");
   AST_TRIP_LATCHED: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) (active_r[REL_TRIP] && !rst_req) |=>
      active_r[REL_TRIP]) else $error("trip relay did not latch");
   AST_AUX2_LATCHED: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) (active_r[REL_AUX2] && !rst_req) |=>
      active_r[REL_AUX2]) else $error("aux2 relay did not latch");
   AST_UNLATCH_DROP: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) (!hit[REL_AUX1] && !latch_r[REL_AUX1]) |=>
      !active_r[REL_AUX1]) else $error("unlatched relay stayed active");
   AST_COIL_POL: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) (coil_out[REL_AUX1] ==
      (fs_r[REL_AUX1] ^ active_r[REL_AUX1])))
      else $error("coil polarity wrong");
   AST_AUX2_FS: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) !active_r[REL_AUX2] |-> coil_out[REL_AUX2])
      else $error("aux2 coil not energized while idle");
   AST_FLASH_END: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) $fell(flash_r) |-> $past(flash_cnt_r) == '0)
      else $error("flash ended early");
   AST_FLASH_START: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) flash_go |=> flash_r ##1
      (view_r.line == $past(flash_line_r)))
      else $error("flash message not shown");
   AST_LINE_RESTORE: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) $fell(flash_r) && !flash_go |=>
      (view_r.line == $past(sel_r.line))) else $error("line not restored");
   AST_OVL_TRIP: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) (therm_r >= THERM_FULL &&
      map_r[REL_TRIP][OVL_BIT]) |=> active_r[REL_TRIP])
      else $error("full thermal memory did not trip");
   AST_MODE_ONEHOT: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) $onehot(sel_r.mode) &&
      (!(sel_r.mode inside {MODE_HELP, MODE_TRIPALARM}) || sel_r.page == '0))
      else $error("bad display mode or page");
   AST_RESET_IGNORED: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) (hit[REL_TRIP] && rst_req) |=>
      active_r[REL_TRIP]) else $error("reset cleared a present condition");

   COV_LATCH_RESET: cover property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) active_r[REL_TRIP] ##1 !active_r[REL_TRIP]);
   COV_FLASH_DONE: cover property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) $fell(flash_r));
   COV_OVERLOAD: cover property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) $rose(overload));
   COV_UNLATCH: cover property (@(posedge sys_clk_in)
      disable iff (!rst_n_in) $fell(active_r[REL_ALARM]) && !rst_req);

endmodule // output_relay_logic
`default_nettype wire

/* hdl/relay_pkg.sv */
`default_nettype none
package relay_pkg;
   // Relay positions
   localparam int          NUM_RELAYS     = 4;
   localparam int          REL_TRIP       = 0;
   localparam int          REL_ALARM      = 1;
   localparam int          REL_AUX1       = 2;
   localparam int          REL_AUX2       = 3;
   localparam logic [3:0]  FORCED_LATCH   = 4'h9;
   localparam logic [3:0]  FORCED_FS      = 4'h8;
   // Conditions: external inputs plus the overload trip at the top bit
   localparam int          COND_W         = 16;
   localparam int          EXT_COND_W     = 15;
   localparam int          OVL_BIT        = 15;
   // Register offsets
   localparam int          ADDR_W         = 8;
   localparam logic [7:0]  ADDR_MAP0      = 8'h00;
   localparam logic [7:0]  ADDR_MAP1      = 8'h04;
   localparam logic [7:0]  ADDR_MAP2      = 8'h08;
   localparam logic [7:0]  ADDR_MAP3      = 8'h0C;
   localparam logic [7:0]  ADDR_LATCH     = 8'h10;
   localparam logic [7:0]  ADDR_FAILSAFE  = 8'h14;
   localparam logic [7:0]  ADDR_STATUS    = 8'h18;
   localparam logic [7:0]  ADDR_DISPLAY   = 8'h1C;
   localparam logic [7:0]  ADDR_FLASH     = 8'h20;
   localparam logic [7:0]  ADDR_THERMAL   = 8'h24;
   // Reset values
   localparam logic [15:0] RST_MAP        = 16'h0000;
   localparam logic [3:0]  RST_LATCH      = 4'h0;
   localparam logic [3:0]  RST_FAILSAFE   = 4'h0;
   localparam logic [15:0] RST_THERMAL    = 16'h0000;
   // Field positions
   localparam int          ST_ACTIVE_LSB  = 0;
   localparam int          ST_COIL_LSB    = 4;
   localparam int          ST_OVL_BIT     = 8;
   localparam int          ST_FLASH_BIT   = 9;
   localparam int          DSP_LINE_LSB   = 0;
   localparam int          DSP_PAGE_LSB   = 8;
   localparam int          DSP_MODE_LSB   = 12;
   // Display geometry
   localparam int          DISP_ROWS      = 2;
   localparam int          DISP_COLS      = 24;
   localparam int          LINE_W         = 8;
   localparam int          PAGE_W         = 4;
   // Thermal memory, full scale stands for 100 percent
   localparam int          THERM_W        = 16;
   localparam logic [15:0] THERM_FULL     = 16'h2710;
   // Flash message time
   localparam int          FLASH_TIME_MS  = 2000;
   localparam int          CLK_FREQ_KHZ   = 100000;
   localparam int          FLASH_CYCLES   = FLASH_TIME_MS * CLK_FREQ_KHZ;

   typedef enum logic [3:0] {
      MODE_ACTUAL    = 4'h1,
      MODE_SETPOINT  = 4'h2,
      MODE_HELP      = 4'h4,
      MODE_TRIPALARM = 4'h8
   } disp_mode_type;

   typedef struct packed {
      disp_mode_type         mode;
      logic [PAGE_W-1:0]     page;
      logic [LINE_W-1:0]     line;
   } disp_view_type;
endpackage
`default_nettype wire

/* sim/protection_output_relay_logic_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module protection_output_relay_logic_bench;
   import relay_pkg::*;
   // Short flash time keeps the run small
   localparam int FL = 20;
   logic          sys_clk, rst_n, wr, rd, heat_v, cool_v, flash_req;
   logic          key_cmd, ext_cmd, key_rst, ext_rst, ovl, flash_on;
   logic [7:0]    addr, flash_line;
   logic [31:0]   wdata, rdata;
   logic [14:0]   cond;
   logic [15:0]   heat_amt, cool_amt;
   logic [3:0]    active, coil, contact;
   disp_view_type view;
   int            miscompares = 0;
   int            n_compared = 0;

   output_relay_logic #(.FLASH_CNT(FL)) output_relay_logic_i (
      .sys_clk_in(sys_clk), .rst_n_in(rst_n), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .cond_in(cond), .heat_valid_in(heat_v),
      .heat_amt_in(heat_amt), .cool_valid_in(cool_v),
      .cool_amt_in(cool_amt), .reset_key_in(key_rst),
      .ext_reset_in(ext_rst), .flash_req_in(flash_req),
      .flash_line_in(flash_line), .relay_active_out(active),
      .coil_out(coil), .overload_trip_out(ovl),
      .disp_view_out(view), .flash_active_out(flash_on));
   relay_field_model relay_field_model_i (
      .sys_clk_in(sys_clk), .rst_n_in(rst_n), .key_cmd_in(key_cmd),
      .ext_cmd_in(ext_cmd), .coil_in(coil), .contact_out(contact),
      .reset_key_out(key_rst), .ext_reset_out(ext_rst));

   always #5 sys_clk = ~sys_clk;

   task automatic close_out;
      if (miscompares == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
         miscompares++;
      end
   endtask
   task automatic chk_pins(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] %0t pins got %h exp %h", $time, got, exp);
         miscompares++;
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic set_cond(input logic [14:0] c);
      @(posedge sys_clk);
      cond <= c;
   endtask
   // Held several cycles, as a real key press is
   task automatic press(input logic use_key);
      @(posedge sys_clk);
      key_cmd <= use_key;
      ext_cmd <= !use_key;
      repeat (3) @(posedge sys_clk);
      key_cmd <= 1'b0;
      ext_cmd <= 1'b0;
      step(3);
   endtask
   task automatic therm_step(input logic up, input logic [15:0] amt);
      @(posedge sys_clk);
      heat_v <= up;
      cool_v <= !up;
      heat_amt <= amt;
      cool_amt <= amt;
      @(posedge sys_clk);
      heat_v <= 1'b0;
      cool_v <= 1'b0;
   endtask

   task automatic s_reset;
      logic [31:0] d;
      chk_pins({8'h00, coil, active}, 16'h0080);
      chk_pins({14'h0, ovl, flash_on}, 16'h0000);
      chk_pins(view, {MODE_ACTUAL, 4'h0, 8'h00});
      for (int i = 0; i < 11; i++) begin
         rd_reg(8'(4 * i), d);
         chk_word(d, (i == 6) ? 32'h0000_0080 : 32'h0000_0000);
      end
   endtask
   task automatic s_trip;
      wr_reg(ADDR_MAP0, 32'h0000_0011);
      set_cond(15'h0010);
      step(1);
      chk_pins({8'h00, coil, active}, 16'h0091);
      press(1'b1);
      chk_pins({12'h000, active}, 16'h0001);
      set_cond(15'h0000);
      step(3);
      chk_pins({12'h000, active}, 16'h0001);
      press(1'b1);
      chk_pins({8'h00, coil, active}, 16'h0080);
   endtask
   task automatic s_alarm;
      logic [31:0] d;
      wr_reg(ADDR_MAP1, 32'h0000_0002);
      set_cond(15'h0002);
      step(1);
      chk_pins({12'h000, active}, 16'h0002);
      set_cond(15'h0000);
      step(1);
      chk_pins({12'h000, active}, 16'h0000);
      wr_reg(ADDR_LATCH, 32'h0000_0002);
      set_cond(15'h0002);
      step(1);
      set_cond(15'h0000);
      step(3);
      chk_pins({12'h000, active}, 16'h0002);
      press(1'b0);
      chk_pins({12'h000, active}, 16'h0000);
      rd_reg(ADDR_LATCH, d);
      chk_word(d, 32'h0000_0002);
   endtask
   task automatic s_failsafe;
      wr_reg(ADDR_FAILSAFE, 32'h0000_0004);
      wr_reg(ADDR_MAP2, 32'h0000_0004);
      step(1);
      chk_pins({12'h000, contact}, 16'h000C);
      set_cond(15'h0004);
      step(1);
      chk_pins({8'h00, coil, active}, 16'h0084);
      set_cond(15'h0000);
      step(1);
      chk_pins({8'h00, coil, active}, 16'h00C0);
   endtask
   task automatic s_thermal;
      logic [31:0] d;
      wr_reg(ADDR_MAP3, 32'h0000_8000);
      wr_reg(ADDR_THERMAL, 32'h0000_270F);
      step(1);
      chk_pins({7'h00, ovl, coil, active}, 16'h00C0);
      therm_step(1'b1, 16'h0001);
      step(1);
      chk_pins({7'h00, ovl, coil, active}, 16'h0148);
      therm_step(1'b1, 16'hFFFF);
      rd_reg(ADDR_THERMAL, d);
      chk_word(d, 32'h0000_2710);
      therm_step(1'b0, 16'hFFFF);
      rd_reg(ADDR_THERMAL, d);
      chk_word(d, 32'h0000_0000);
      step(1);
      chk_pins({7'h00, ovl, coil, active}, 16'h0048);
      press(1'b0);
      chk_pins({12'h000, active}, 16'h0000);
   endtask
   task automatic s_display;
      for (int m = 0; m < 4; m++) begin
         wr_reg(ADDR_DISPLAY, (32'(m) << 12) | 32'h0000_0207);
         step(2);
         chk_pins(view, {4'(1 << m), (m < 2) ? 4'h2 : 4'h0, 8'h07});
      end
   endtask
   task automatic flash_run(input logic via_reg, input logic [7:0] ln);
      int n;
      if (via_reg) begin
         wr_reg(ADDR_FLASH, {24'h0, ln});
      end else begin
         @(posedge sys_clk);
         flash_req <= 1'b1;
         flash_line <= ln;
         @(posedge sys_clk);
         flash_req <= 1'b0;
      end
      #1;
      n = 0;
      while (flash_on === 1'b1 && n < 100) begin
         if (n == 4) chk_pins(view, {MODE_ACTUAL, 4'h1, ln});
         n++;
         step(1);
      end
      if (n == 100) begin
         miscompares++;
         close_out;
      end
      chk_word(32'(n), 32'(FL));
      step(1);
      chk_pins(view, {MODE_ACTUAL, 4'h1, 8'h03});
   endtask

   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      {wr, rd, heat_v, cool_v, flash_req, key_cmd, ext_cmd} = 7'h00;
      addr = 8'h00;
      wdata = 32'h0;
      cond = 15'h0;
      heat_amt = 16'h0;
      cool_amt = 16'h0;
      flash_line = 8'h00;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      step(1);
      s_reset;
      s_trip;
      s_alarm;
      s_failsafe;
      s_thermal;
      s_display;
      wr_reg(ADDR_DISPLAY, 32'h0000_0103);
      step(2);
      flash_run(1'b0, 8'h05);
      flash_run(1'b1, 8'h06);
      close_out;
   end
endmodule // protection_output_relay_logic_bench
`default_nettype wire

/* sim/relay_field_model.sv */
`timescale 1ns/1ps
`default_nettype none
module relay_field_model (
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   // Operator commands
   input  wire logic       key_cmd_in,
   input  wire logic       ext_cmd_in,
   // Coil drive
   input  wire logic [3:0] coil_in,
   // Reset lines and contacts
   output logic      [3:0] contact_out,
   output logic            reset_key_out,
   output logic            ext_reset_out
);
   // Sampled once a cycle; key bounce is not modelled
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reset_key_out <= 1'b0;
         ext_reset_out <= 1'b0;
      end else begin
         reset_key_out <= key_cmd_in;
         ext_reset_out <= ext_cmd_in;
      end
   end
   // Normally open contact closes on an energized coil
   assign contact_out = coil_in;
endmodule // relay_field_model
`default_nettype wire
